/* File: verilog/flash_factory_stream_program.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_factory_stream_program #(
  parameter int ADDR_W = flash_seq_pkg::DEF_ADDR_W,
  parameter int BLOCK_BITS = flash_seq_pkg::DEF_BLOCK_BITS,
  parameter int MAX_RETRY = flash_seq_pkg::DEF_MAX_RETRY
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] arr_addr,
  output logic [flash_seq_pkg::WORD_W-1:0] arr_wdata,
  output logic arr_prog,
  input wire logic arr_done,
  input wire logic [flash_seq_pkg::WORD_W-1:0] arr_rdata,
  input wire logic vpp_ok,
  input wire logic block_locked,
  output logic factory_busy
);
  import flash_seq_pkg::*;

  // Refuse shapes that the page and block arithmetic cannot serve
  if (BLOCK_BITS <= PAGE_BITS || BLOCK_BITS >= ADDR_W || ADDR_W > 32)
  begin : g_bad_shape
    $error("flash_factory_stream_program: bad ADDR_W or BLOCK_BITS");
  end
  if (MAX_RETRY < 1 || MAX_RETRY > 255)
  begin : g_bad_retry
    $error("flash_factory_stream_program: MAX_RETRY out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers to the helper modules
  err_link_if err_link ();
  page_link_if page_link ();

  err_flags u_err_flags (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .link(err_link.keeper)
  );

  page_buffer u_page_buffer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .link(page_link.store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State and datapath registers
  seq_state_e state_reg, state_next;
  logic [ADDR_W-1:0] flash_addr_reg;
  logic [ADDR_W-1:0] start_reg, start_next;
  logic [ADDR_W-1:0] loc_reg, loc_next;
  logic [WORD_W-1:0] word_reg, word_next;
  logic first_reg, first_next;
  logic ver_reg, ver_next;
  logic quad_reg, quad_next;
  logic rs_mode_reg, rs_mode_next;
  logic [PAGE_BITS-1:0] qidx_reg, qidx_next;
  logic [7:0] retry_reg, retry_next;
  logic [ADDR_W-1:0] arr_addr_reg;
  logic [WORD_W-1:0] arr_wdata_reg;
  logic [31:0] prdata_reg;
  logic [ERR_W-1:0] err_set;
  logic err_clear;
  logic buf_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes with no wait state
  wire apb_access = psel && penable;
  wire hit_addr = (paddr == ADDR_OFS);
  wire hit_data = (paddr == DATA_OFS);
  wire hit_status = (paddr == STATUS_OFS);
  wire hit_info = (paddr == INFO_OFS);
  wire mapped = hit_addr || hit_data || hit_status || hit_info;
  wire bus_wr = apb_access && pwrite && hit_data;
  wire addr_wr = apb_access && pwrite && hit_addr;
  wire [WORD_W-1:0] bus_data = pwdata[WORD_W-1:0];
  wire [7:0] bus_cmd = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = apb_access && !mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // Address helpers: block compare and page base
  function automatic logic same_block(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    same_block = (a[ADDR_W-1:BLOCK_BITS] == b[ADDR_W-1:BLOCK_BITS]);
  endfunction : same_block

  function automatic logic [ADDR_W-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = {a[ADDR_W-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
  endfunction : page_of

  wire in_block = same_block(flash_addr_reg, start_reg);
  wire is_erased = (bus_data == ERASED_WORD);
  wire at_start = (flash_addr_reg == start_reg);
  // Start address is known once the first program or page word is in
  wire start_known = !first_reg || ver_reg;
  wire leave_write = start_known && !in_block;
  wire retry_spent = (retry_reg == 8'(MAX_RETRY));

  // Word and address handed to the array by the active phase
  wire [WORD_W-1:0] cur_word = quad_reg ? page_link.rd_data : word_reg;
  wire word_op = (state_reg == S_WORD_PGM) || (state_reg == S_WORD_CHECK);
  wire [ADDR_W-1:0] op_addr = quad_reg ? {loc_reg[ADDR_W-1:PAGE_BITS], qidx_reg} : loc_reg;
  wire [ADDR_W-1:0] arr_addr_sel = word_op ? op_addr : flash_addr_reg;
  // Address and data flops lag by one cycle; act only once they settle
  wire arr_stable = (arr_addr_reg == arr_addr_sel) && (arr_wdata_reg == cur_word);
  wire word_match = (arr_rdata == arr_wdata_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Status byte and flags
  wire ready_flag = (state_reg == S_IDLE) || (state_reg == S_EFP_CONFIRM)
    || (((state_reg == S_EFP_PROG) || (state_reg == S_QLOAD)) && first_reg);
  wire wait_flag = word_op;
  wire [7:0] status_byte = {ready_flag, 1'b0, err_link.flags[ERR_ERASE],
    err_link.flags[ERR_PROGRAM], err_link.flags[ERR_SUPPLY], 1'b0,
    err_link.flags[ERR_LOCK], wait_flag};

  // Other banks and the suspend path see this and refuse while busy
  assign factory_busy = (state_reg != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer next-state logic
  always_comb
  begin
    state_next = state_reg;
    start_next = start_reg;
    loc_next = loc_reg;
    word_next = word_reg;
    first_next = first_reg;
    ver_next = ver_reg;
    quad_next = quad_reg;
    rs_mode_next = rs_mode_reg;
    qidx_next = qidx_reg;
    retry_next = retry_reg;
    err_set = '0;
    err_clear = 1'b0;
    buf_wr = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        if (bus_wr)
        begin
          case (bus_cmd)
            CMD_EFP_SETUP:
            begin
              state_next = S_EFP_CONFIRM;
              rs_mode_next = 1'b1;
            end
            CMD_QEFP_SETUP:
            begin
              rs_mode_next = 1'b1;
              if (!vpp_ok)
              begin
                err_set[ERR_SUPPLY] = 1'b1;
                err_set[ERR_PROGRAM] = 1'b1;
              end
              else if (block_locked)
              begin
                err_set[ERR_LOCK] = 1'b1;
                err_set[ERR_PROGRAM] = 1'b1;
              end
              else
              begin
                state_next = S_QLOAD;
                quad_next = 1'b1;
                ver_next = 1'b0;
                first_next = 1'b1;
                qidx_next = '0;
              end
            end
            CMD_CLEAR_STATUS: err_clear = 1'b1;
            CMD_READ_STATUS: rs_mode_next = 1'b1;
            CMD_READ_ARRAY: rs_mode_next = 1'b0;
            default: ;
          endcase
        end
      end
      S_EFP_CONFIRM:
      begin
        if (bus_wr)
        begin
          if (bus_cmd != CMD_CONFIRM)
          begin
            // Wrong second write aborts and marks a sequence error
            err_set[ERR_ERASE] = 1'b1;
            err_set[ERR_PROGRAM] = 1'b1;
            state_next = S_IDLE;
          end
          else if (!vpp_ok)
          begin
            err_set[ERR_SUPPLY] = 1'b1;
            err_set[ERR_PROGRAM] = 1'b1;
            state_next = S_IDLE;
          end
          else if (block_locked)
          begin
            err_set[ERR_LOCK] = 1'b1;
            err_set[ERR_PROGRAM] = 1'b1;
            state_next = S_IDLE;
          end
          else
          begin
            state_next = S_EFP_PROG;
            quad_next = 1'b0;
            ver_next = 1'b0;
            first_next = 1'b1;
          end
        end
      end
      S_EFP_PROG, S_EFP_VER:
      begin
        // Writes that arrive while the word engine is busy are dropped
        if (bus_wr && leave_write)
        begin
          if (is_erased && ver_reg)
            state_next = S_IDLE;
          else if (is_erased)
          begin
            state_next = S_EFP_VER;
            ver_next = 1'b1;
            first_next = 1'b1;
          end
        end
        else if (bus_wr)
        begin
          word_next = bus_data;
          first_next = 1'b0;
          retry_next = '0;
          if (first_reg || !at_start)
            loc_next = flash_addr_reg;
          else
            loc_next = loc_reg + ADDR_W'(1);
          if (first_reg && !ver_reg)
            start_next = flash_addr_reg;
          state_next = ver_reg ? S_WORD_CHECK : S_WORD_PGM;
        end
      end
      S_WORD_PGM:
      begin
        if (arr_prog && arr_done)
          state_next = (quad_reg || ver_reg) ? S_WORD_CHECK : S_EFP_PROG;
      end
      S_WORD_CHECK:
      begin
        if (arr_stable && (word_match || retry_spent))
        begin
          err_set[ERR_PROGRAM] = !word_match;
          retry_next = '0;
          if (!quad_reg)
            state_next = S_EFP_VER;
          else if (qidx_reg == PAGE_BITS'(PAGE_WORDS - 1))
          begin
            state_next = S_QLOAD;
            qidx_next = '0;
          end
          else
          begin
            state_next = S_WORD_PGM;
            qidx_next = qidx_reg + PAGE_BITS'(1);
          end
        end
        else if (arr_stable)
        begin
          retry_next = retry_reg + 8'(1);
          state_next = S_WORD_PGM;
        end
      end
      S_QLOAD:
      begin
        if (bus_wr && qidx_reg == '0 && leave_write)
        begin
          if (is_erased)
          begin
            state_next = S_IDLE;
            quad_next = 1'b0;
          end
        end
        else if (bus_wr && qidx_reg == '0)
        begin
          buf_wr = 1'b1;
          qidx_next = PAGE_BITS'(1);
          first_next = 1'b0;
          if (first_reg)
            start_next = flash_addr_reg;
          if (!first_reg && at_start)
            loc_next = loc_reg + ADDR_W'(PAGE_WORDS);
          else
            loc_next = page_of(flash_addr_reg);
        end
        else if (bus_wr)
        begin
          // Address ignored here: slot order is fixed
          buf_wr = 1'b1;
          retry_next = '0;
          if (qidx_reg == PAGE_BITS'(PAGE_WORDS - 1))
          begin
            state_next = S_WORD_PGM;
            qidx_next = '0;
          end
          else
            qidx_next = qidx_reg + PAGE_BITS'(1);
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg <= S_IDLE;
      start_reg <= '0;
      loc_reg <= '0;
      word_reg <= ERASED_WORD;
      first_reg <= 1'b0;
      ver_reg <= 1'b0;
      quad_reg <= 1'b0;
      rs_mode_reg <= 1'b0;
      qidx_reg <= '0;
      retry_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      start_reg <= start_next;
      loc_reg <= loc_next;
      word_reg <= word_next;
      first_reg <= first_next;
      ver_reg <= ver_next;
      quad_reg <= quad_next;
      rs_mode_reg <= rs_mode_next;
      qidx_reg <= qidx_next;
      retry_reg <= retry_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array side: registered address and data, request held until done
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      arr_addr_reg <= '0;
      arr_wdata_reg <= ERASED_WORD;
    end
    else
    begin
      arr_addr_reg <= arr_addr_sel;
      arr_wdata_reg <= cur_word;
    end
  end

  assign arr_addr = arr_addr_reg;
  assign arr_wdata = arr_wdata_reg;
  assign arr_prog = (state_reg == S_WORD_PGM) && arr_stable;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper carriers
  assign err_link.set = err_set;
  assign err_link.clear = err_clear;
  assign page_link.wr_en = buf_wr;
  assign page_link.wr_idx = qidx_reg;
  assign page_link.wr_data = bus_data;
  assign page_link.rd_idx = qidx_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Software flash address register
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      flash_addr_reg <= FLASH_ADDR_RST[ADDR_W-1:0];
    else if (addr_wr)
      flash_addr_reg <= pwdata[ADDR_W-1:0];
  end

  // Read mux; data window shows status whenever status mode is selected
  wire [31:0] info_word = {24'h00_0000, factory_busy, quad_reg, ver_reg,
    rs_mode_reg, 1'b0, state_reg};
  wire [31:0] data_word = rs_mode_reg ? {24'h00_0000, status_byte}
    : {16'h0000, arr_rdata};
  wire [31:0] rd_sel = hit_addr ? 32'(flash_addr_reg)
    : hit_data ? data_word
    : hit_status ? {24'h00_0000, status_byte}
    : hit_info ? info_word : 32'h0000_0000;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      prdata_reg <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_reg <= rd_sel;
  end

  assign prdata = prdata_reg;
endmodule : flash_factory_stream_program
`default_nettype wire

/* File: verilog/flash_seq_pkg.sv */
`default_nettype none
package flash_seq_pkg;
  // APB register map, byte offsets
  localparam logic [7:0] ADDR_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] INFO_OFS = 8'h0c;
  localparam logic [31:0] FLASH_ADDR_RST = 32'h0000_0000;

  // Command codes seen in the low byte of a flash bus write
  localparam logic [7:0] CMD_EFP_SETUP = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_QEFP_SETUP = 8'h75;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;

  // Data word, page and defaults
  localparam int WORD_W = 16;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
  localparam int PAGE_WORDS = 4;
  localparam int PAGE_BITS = 2;
  localparam int DEF_ADDR_W = 22;
  localparam int DEF_BLOCK_BITS = 15;
  localparam int DEF_MAX_RETRY = 4;

  // Status byte bit positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE = 5;
  localparam int SR_PROGRAM = 4;
  localparam int SR_SUPPLY = 3;
  localparam int SR_LOCK = 1;
  localparam int SR_WAIT = 0;

  // Sticky error vector positions
  localparam int ERR_W = 4;
  localparam int ERR_LOCK = 0;
  localparam int ERR_SUPPLY = 1;
  localparam int ERR_PROGRAM = 2;
  localparam int ERR_ERASE = 3;

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_EFP_CONFIRM = 3'b001,
    S_EFP_PROG = 3'b010,
    S_EFP_VER = 3'b011,
    S_WORD_PGM = 3'b100,
    S_WORD_CHECK = 3'b101,
    S_QLOAD = 3'b110
  } seq_state_e;
endpackage : flash_seq_pkg
`default_nettype wire

/* File: verilog/seq_links.sv */
`timescale 1ns/10ps
`default_nettype none
// Sticky error flags: set vector from the sequencer, clear by command
interface err_link_if;
  import flash_seq_pkg::*;
  logic [ERR_W-1:0] set;
  logic clear;
  logic [ERR_W-1:0] flags;
  modport seq (output set, output clear, input flags);
  modport keeper (input set, input clear, output flags);
endinterface : err_link_if

////////////////////////////////////////////////////////////////////////////////
// Page buffer write and read ports
interface page_link_if;
  import flash_seq_pkg::*;
  logic wr_en;
  logic [PAGE_BITS-1:0] wr_idx;
  logic [WORD_W-1:0] wr_data;
  logic [PAGE_BITS-1:0] rd_idx;
  logic [WORD_W-1:0] rd_data;
  modport seq (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : page_link_if
`default_nettype wire

/* File: verilog/err_flags.sv */
`timescale 1ns/10ps
`default_nettype none
module err_flags (
  input wire logic clk_sys,
  input wire logic reset_n,
  err_link_if.keeper link
);
  import flash_seq_pkg::*;

  logic [ERR_W-1:0] flag_reg;

  // Each flag holds until cleared; a set in the clear cycle still wins
  for (genvar i = 0; i < ERR_W; i++)
  begin : g_flag
    always_ff @(posedge clk_sys)
    begin
      if (!reset_n)
        flag_reg[i] <= 1'b0;
      else if (link.set[i])
        flag_reg[i] <= 1'b1;
      else if (link.clear)
        flag_reg[i] <= 1'b0;
    end
  end

  assign link.flags = flag_reg;
endmodule : err_flags
`default_nettype wire

/* File: verilog/page_buffer.sv */
`timescale 1ns/10ps
`default_nettype none
module page_buffer (
  input wire logic clk_sys,
  input wire logic reset_n,
  page_link_if.store link
);
  import flash_seq_pkg::*;

  logic [WORD_W-1:0] word_reg [PAGE_WORDS];

  // One flip-flop word per page slot, written by index
  for (genvar i = 0; i < PAGE_WORDS; i++)
  begin : g_word
    always_ff @(posedge clk_sys)
    begin
      if (!reset_n)
        word_reg[i] <= ERASED_WORD;
      else if (link.wr_en && link.wr_idx == PAGE_BITS'(i))
        word_reg[i] <= link.wr_data;
    end
  end

  assign link.rd_data = word_reg[link.rd_idx];
endmodule : page_buffer
`default_nettype wire

/* File: verif/flash_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_monitor #(
  parameter int ADDR_W = flash_seq_pkg::DEF_ADDR_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ADDR_W-1:0] arr_addr,
  input wire logic [flash_seq_pkg::WORD_W-1:0] arr_wdata,
  input wire logic arr_prog,
  input wire logic arr_done,
  input wire logic [flash_seq_pkg::WORD_W-1:0] arr_rdata,
  input wire logic vpp_ok,
  input wire logic block_locked,
  input wire logic factory_busy
);
  import flash_seq_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic mapped;
  logic data_wr;
  // Bus decode; the map has four aligned words only
  assign mapped = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
  assign data_wr = psel && penable && pwrite && (paddr == DATA_OFS);
  ////////////////////////////////////////
  // Array handshake steps
  sequence s_prog_wait;
    arr_prog && !arr_done;
  endsequence
  sequence s_prog_ack;
    arr_prog && arr_done;
  endsequence
  a_prog_busy: assert property (arr_prog |-> factory_busy)
    else $error("array program outside a factory command");
  a_prog_holds: assert property (s_prog_wait |=> arr_prog)
    else $error("program request dropped before done");
  a_prog_stable: assert property (s_prog_wait |=> $stable(arr_addr) && $stable(arr_wdata))
    else $error("array address or data moved during program");
  a_prog_ends: assert property (s_prog_ack |=> !arr_prog)
    else $error("program request held after done");
  // The page command only starts with a good supply and an unlocked block
  a_setup_busy: assert property (data_wr && !factory_busy &&
    (pwdata[7:0] == CMD_EFP_SETUP || (pwdata[7:0] == CMD_QEFP_SETUP && vpp_ok
    && !block_locked)) |=> factory_busy)
    else $error("setup code did not start the sequencer");
  a_slverr_map: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  a_slverr_only: assert property (pslverr |-> psel && penable && !mapped)
    else $error("error response for a mapped access");
  a_pready_high: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule : flash_monitor
bind flash_factory_stream_program flash_monitor #(.ADDR_W(ADDR_W)) mon_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_prog(arr_prog), .arr_done(arr_done),
  .arr_rdata(arr_rdata), .vpp_ok(vpp_ok), .block_locked(block_locked),
  .factory_busy(factory_busy)
);
`default_nettype wire

/* File: verif/flash_array_model.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_array_model #(
  parameter int ADDR_W = 22
) (
  input wire logic clk_sys,
  input wire logic [ADDR_W-1:0] arr_addr,
  input wire logic [15:0] arr_wdata,
  input wire logic arr_prog,
  output logic arr_done,
  output logic [15:0] arr_rdata
);
  logic [15:0] mem [0:255];
  logic [8:0] stuck = 9'h1ff;
  int lat = 0;
  int cnt = 0;
  // Erased array at start
  initial
  begin
    arr_done = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
  end
  // Only 256 words are kept, so tests stay inside one window
  assign arr_rdata = mem[arr_addr[7:0]];
  // Cells only clear bits; a stuck word never changes, which forces verify failures
  always @(posedge clk_sys)
  begin
    arr_done <= 1'b0;
    if (arr_prog && !arr_done)
    begin
      cnt <= (cnt >= lat) ? 0 : cnt + 1;
      if (cnt >= lat) arr_done <= 1'b1;
      if (cnt >= lat && {1'b0, arr_addr[7:0]} != stuck)
        mem[arr_addr[7:0]] <= mem[arr_addr[7:0]] & arr_wdata;
    end
  end
endmodule : flash_array_model
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import flash_seq_pkg::*;
  localparam logic [21:0] OUT_BLK = 22'h008000;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic vpp_ok = 1'b1;
  logic block_locked = 1'b0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, arr_prog, arr_done, factory_busy, errv;
  logic [21:0] arr_addr;
  logic [15:0] arr_wdata, arr_rdata;
  int error_cnt = 0;
  int tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  flash_factory_stream_program dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_prog(arr_prog), .arr_done(arr_done), .arr_rdata(arr_rdata), .vpp_ok(vpp_ok),
    .block_locked(block_locked), .factory_busy(factory_busy));
  flash_array_model model_u (.clk_sys(clk_sys), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_prog(arr_prog), .arr_done(arr_done), .arr_rdata(arr_rdata));
  ////////////////////////////////////////
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen at a rising edge
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task stat_chk(input logic [7:0] e);
    bus(STATUS_OFS, 1'b0, 32'h0);
    chk("status", {24'h0, e}, rdv);
  endtask : stat_chk
  // Flash bus write: address register, then the data window
  task fw(input logic [21:0] a, input logic [15:0] d);
    wr(ADDR_OFS, {10'h0, a});
    wr(DATA_OFS, {16'h0, d});
  endtask : fw
  // Polls write-wait, since words sent while it is high are dropped
  task poll;
    bus(STATUS_OFS, 1'b0, 32'h0);
    repeat (400) if (rdv[SR_WAIT] !== 1'b0) bus(STATUS_OFS, 1'b0, 32'h0);
    chk("write-wait", 32'h0, {31'h0, rdv[SR_WAIT]});
  endtask : poll
  task mem_chk(input logic [7:0] i, input logic [15:0] e);
    chk("array word", {16'h0, e}, {16'h0, model_u.mem[i]});
  endtask : mem_chk
  ////////////////////////////////////////
  task t_idle;
    stat_chk(8'h80);
    chk("busy", 32'h0, {31'h0, factory_busy});
    bus(8'h10, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, errv});
    $display("idle test done");
  endtask : t_idle
  // Stream with one stuck word: auto-increment, jump, ignored and real terminators
  task t_stream;
    model_u.stuck = 9'h041;
    fw(22'h40, 16'h0030);
    wr(DATA_OFS, 32'hd0);
    bus(DATA_OFS, 1'b0, 32'h0);
    chk("window after confirm", 32'h80, {24'h0, rdv[7:0]});
    for (int p = 0; p < 2; p++)
    begin
      fw(22'h40, 16'h1111);
      poll;
      fw(22'h40, 16'h2222);
      poll;
      fw(22'h45, 16'h3333);
      poll;
      fw(OUT_BLK, 16'h1234);
      bus(INFO_OFS, 1'b0, 32'h0);
      chk("verify flag", 32'(p), {31'h0, rdv[5]});
      fw(OUT_BLK, 16'hffff);
      if (p == 0) bus(INFO_OFS, 1'b0, 32'h0);
      if (p == 0) chk("verify flag", 32'h1, {31'h0, rdv[5]});
    end
    mem_chk(8'h40, 16'h1111);
    mem_chk(8'h45, 16'h3333);
    // An ignored terminator must not have been programmed as data either
    mem_chk(8'h00, 16'hffff);
    stat_chk(8'h90);
    bus(DATA_OFS, 1'b0, 32'h0);
    chk("window after exit", 32'h90, {24'h0, rdv[7:0]});
    wr(DATA_OFS, {24'h0, CMD_CLEAR_STATUS});
    stat_chk(8'h80);
    model_u.stuck = 9'h1ff;
    $display("stream test done");
  endtask : t_stream
  // Two pages with a slow array; later words carry the last slot's address in the first page, the start address in the second
  task t_page;
    model_u.lat = 20;
    fw(22'h80, 16'h0075);
    fw(22'h80, 16'ha000);
    stat_chk(8'h00);
    wr(ADDR_OFS, 32'h83);
    for (int i = 1; i < 4; i++) wr(DATA_OFS, 32'ha000 + i);
    stat_chk(8'h01);
    chk("busy", 32'h1, {31'h0, factory_busy});
    poll;
    stat_chk(8'h00);
    for (int i = 0; i < 4; i++) mem_chk(8'(8'h80 + i), 16'(16'ha000 + i));
    fw(22'h80, 16'hb000);
    for (int i = 1; i < 4; i++) wr(DATA_OFS, 32'hb000 + i);
    poll;
    for (int i = 0; i < 4; i++) mem_chk(8'(8'h84 + i), 16'(16'hb000 + i));
    fw(OUT_BLK, 16'hffff);
    stat_chk(8'h80);
    $display("page test done");
  endtask : t_page
  // Refused starts: bad confirm, low supply, locked block; then both read modes
  task t_abort;
    fw(22'h40, 16'h0030);
    wr(DATA_OFS, 32'h0);
    stat_chk(8'hb0);
    wr(DATA_OFS, {24'h0, CMD_CLEAR_STATUS});
    stat_chk(8'h80);
    vpp_ok <= 1'b0;
    fw(22'h80, 16'h0075);
    stat_chk(8'h98);
    chk("busy", 32'h0, {31'h0, factory_busy});
    vpp_ok <= 1'b1;
    block_locked <= 1'b1;
    wr(DATA_OFS, {24'h0, CMD_CLEAR_STATUS});
    fw(22'h40, 16'h0030);
    wr(DATA_OFS, 32'hd0);
    stat_chk(8'h92);
    block_locked <= 1'b0;
    wr(DATA_OFS, {24'h0, CMD_CLEAR_STATUS});
    wr(DATA_OFS, {24'h0, CMD_READ_ARRAY});
    bus(DATA_OFS, 1'b0, 32'h0);
    chk("array window", 32'h1111, rdv);
    wr(DATA_OFS, {24'h0, CMD_READ_STATUS});
    bus(DATA_OFS, 1'b0, 32'h0);
    chk("status window", 32'h80, rdv);
    $display("abort test done");
  endtask : t_abort
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_idle;
    t_stream;
    t_page;
    t_abort;
    conclude;
  end
  // Watchdog well past the expected run length
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    conclude;
  end
endmodule : testbench
`default_nettype wire
